// file: temp_alarm_pkg.sv
/*
 * Shared constants for the temperature formatter and limit alarm block,
 * plus the per-limit hysteresis comparator cell.
 * Assumes one system clock and an active-low asynchronous reset.
 */
`default_nettype none

package temp_alarm_pkg;
	// Conversion channel codes from the front end
	localparam logic [1:0] CH_LOCAL = 2'h0;
	localparam logic [1:0] CH_REM1  = 2'h1;
	localparam logic [1:0] CH_REM2  = 2'h2;

	// Channel bit positions in enable, mask and status vectors
	localparam int BIT_LOC  = 0;
	localparam int BIT_REM1 = 1;
	localparam int BIT_REM2 = 2;

	// Stored reading words
	localparam int NUM_WORDS = 5;
	localparam logic [2:0] W_LOC_S  = 3'h0;
	localparam logic [2:0] W_REM1_S = 3'h1;
	localparam logic [2:0] W_REM2_S = 3'h2;
	localparam logic [2:0] W_REM1_U = 3'h3;
	localparam logic [2:0] W_REM2_U = 3'h4;

	// Read selects: pair index in [3:1], low byte when bit 0 set
	localparam logic [3:0] RD_STATUS2 = 4'hA;
	localparam logic [3:0] RD_STATUS3 = 4'hB;
	localparam logic [3:0] RD_STATUS4 = 4'hC;

	// Configuration write selects
	localparam logic [3:0] CFG_LOC_LIM   = 4'h0;
	localparam logic [3:0] CFG_REM1_LIM1 = 4'h1;
	localparam logic [3:0] CFG_REM2_LIM1 = 4'h2;
	localparam logic [3:0] CFG_REM1_LIM2 = 4'h3;
	localparam logic [3:0] CFG_REM2_LIM2 = 4'h4;
	localparam logic [3:0] CFG_HYST      = 4'h5;
	localparam logic [3:0] CFG_MASK1     = 4'h6;
	localparam logic [3:0] CFG_MASK2     = 4'h7;
	localparam logic [3:0] CFG_MASK3     = 4'h8;

	// Limit, hysteresis and mask reset values (whole degrees)
	localparam logic [7:0] LIM_85_DEF  = 8'h55;
	localparam logic [7:0] LIM_110_DEF = 8'h6E;
	localparam logic [7:0] HYST_DEF    = 8'h05;
	localparam logic [2:0] MASK1_DEF   = 3'h1;
	localparam logic [2:0] MASK2_DEF   = 3'h0;
	localparam logic [2:0] MASK3_DEF   = 3'h7;

	// Raw input is signed, one step = 1/32 degree
	localparam logic signed [15:0] RAW_S_MAX = 16'sh0FFF;
	localparam logic signed [15:0] RAW_S_MIN = 16'shF000;
	localparam logic signed [15:0] RAW_U_MAX = 16'sh1FFF;
	localparam logic signed [15:0] RAW_ZERO  = 16'sh0000;
	localparam int FRAC_SHIFT = 3;

	// Bits kept in the left-justified word per resolution
	localparam logic [15:0] MASK_COARSE = 16'hFFE0;
	localparam logic [15:0] MASK_FINE   = 16'hFFF8;

	// Readings forced on a diode fault
	localparam logic [15:0] FAULT_S = 16'h8000;
	localparam logic [15:0] FAULT_U = 16'h0000;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
endpackage : temp_alarm_pkg

/* Hysteresis comparator: sets above the limit, clears below limit-hyst */
module limit_hyst_cell (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Conversion result
	input  wire logic        update,
	input  wire logic [15:0] temp,
	// Thresholds
	input  wire logic [7:0]  limit,
	input  wire logic [7:0]  hyst,
	// Result
	output logic             over_q
);
	logic signed [16:0] temp_x;
	logic signed [16:0] set_lvl;
	logic signed [16:0] clr_lvl;
	logic signed [8:0]  clr_deg;

	// Limits are whole degrees; words carry degrees in the upper byte
	assign temp_x  = {temp[15], temp};
	assign set_lvl = {limit[7], limit, 8'h00};
	assign clr_deg = 9'($signed({limit[7], limit}) - $signed({1'b0, hyst}));
	assign clr_lvl = {clr_deg, 8'h00};

	// State held between conversions; only a fresh reading moves it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			over_q <= 1'b0;
		end else if (update) begin
			if (temp_x > set_lvl) begin
				over_q <= 1'b1;
			end else if (temp_x < clr_lvl) begin
				over_q <= 1'b0;
			end
		end
	end
endmodule : limit_hyst_cell

`default_nettype wire

// file: temp_alarm_top.sv
/*
 * Temperature formatter, coherent byte readback and limit alarms.
 * Assumes one-cycle converter results on their own clock, spaced far
 * apart, with channel, raw 1/32 degree value and fault flag.
 */
`default_nettype none

module temp_alarm_top (
	// Clocks and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        conv_clk,
	// Conversion results, conv_clk domain
	input  wire logic        conv_valid,
	input  wire logic [1:0]  conv_chan,
	input  wire logic [15:0] conv_raw,
	input  wire logic        conv_fault,
	// Channel and filter enables
	input  wire logic [2:0]  chan_enable,
	input  wire logic [1:0]  filter_enable,
	// Limit, hysteresis and mask writes
	input  wire logic        cfg_we,
	input  wire logic [3:0]  cfg_sel,
	input  wire logic [7:0]  cfg_wdata,
	// Byte readback
	input  wire logic        rd_en,
	input  wire logic [3:0]  rd_sel,
	output logic [7:0]       rd_data_q,
	// Serial data pin
	input  wire logic        sda_drive_low,
	output logic             sda_o,
	output logic             sda_oe,
	// Alarm pins, open drain
	output logic             alarm_out_one_o,
	output logic             alarm_out_one_oe,
	output logic             alarm_out_two_o,
	output logic             alarm_out_two_oe,
	output logic             alarm_out_three_o,
	output logic             alarm_out_three_oe
);
	// Converter-side holding registers
	logic        hold_tgl_q;
	logic [1:0]  hold_chan_q;
	logic [15:0] hold_raw_q;
	logic        hold_fault_q;
	// Crossing into clk
	logic        tgl_s1_q, tgl_s2_q, tgl_s3_q;
	logic        new_conv;
	// Formatted readings
	logic [15:0] word_q [temp_alarm_pkg::NUM_WORDS];
	logic [15:0] fmt_s;
	logic [15:0] fmt_u;
	logic        fine;
	// Per-word low byte freeze
	logic [temp_alarm_pkg::NUM_WORDS-1:0] lock_q;
	logic [7:0]  lo_hold_q [temp_alarm_pkg::NUM_WORDS];
	logic [2:0]  rd_pair;
	// Configuration
	logic [7:0]  loc_lim_q;
	logic [7:0]  rem1_lim1_q;
	logic [7:0]  rem2_lim1_q;
	logic [7:0]  rem1_lim2_q;
	logic [7:0]  rem2_lim2_q;
	logic [7:0]  hyst_q;
	logic [2:0]  mask1_q;
	logic [2:0]  mask2_q;
	logic [2:0]  mask3_q;
	// Comparison results
	logic        upd_loc, upd_rem1, upd_rem2;
	logic        loc_over, rem1_over1, rem2_over1;
	logic        rem1_over2, rem2_over2;
	logic [2:0]  status2, status3, status4;

	// Clamp to signed range, left justify, drop unused fraction bits
	function automatic logic [15:0] fmt_signed(
		input logic signed [15:0] raw,
		input logic               keep_fine
	);
		logic signed [15:0] c;
		c = raw;
		if (raw > temp_alarm_pkg::RAW_S_MAX) begin
			c = temp_alarm_pkg::RAW_S_MAX;
		end else if (raw < temp_alarm_pkg::RAW_S_MIN) begin
			c = temp_alarm_pkg::RAW_S_MIN;
		end
		fmt_signed = 16'(c <<< temp_alarm_pkg::FRAC_SHIFT)
			& (keep_fine ? temp_alarm_pkg::MASK_FINE
			: temp_alarm_pkg::MASK_COARSE);
	endfunction : fmt_signed

	// Clamp to 0..255.96875, left justify, drop unused fraction bits
	function automatic logic [15:0] fmt_unsigned(
		input logic signed [15:0] raw,
		input logic               keep_fine
	);
		logic signed [15:0] c;
		c = raw;
		if (raw > temp_alarm_pkg::RAW_U_MAX) begin
			c = temp_alarm_pkg::RAW_U_MAX;
		end else if (raw < temp_alarm_pkg::RAW_ZERO) begin
			c = temp_alarm_pkg::RAW_ZERO;
		end
		fmt_unsigned = 16'(c <<< temp_alarm_pkg::FRAC_SHIFT)
			& (keep_fine ? temp_alarm_pkg::MASK_FINE
			: temp_alarm_pkg::MASK_COARSE);
	endfunction : fmt_unsigned

	// Converter side: park the result and flip the event toggle on the same edge
	always_ff @(posedge conv_clk or negedge nrst) begin
		if (!nrst) begin
			hold_tgl_q   <= 1'b0;
			hold_chan_q  <= temp_alarm_pkg::CH_LOCAL;
			hold_raw_q   <= temp_alarm_pkg::WORD_ZERO;
			hold_fault_q <= 1'b0;
		end else if (conv_valid) begin
			hold_tgl_q   <= ~hold_tgl_q;
			hold_chan_q  <= conv_chan;
			hold_raw_q   <= conv_raw;
			hold_fault_q <= conv_fault;
		end
	end

	// Toggle synchroniser; parked data is stable long before it lands
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
		end else begin
			tgl_s1_q <= hold_tgl_q;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
		end
	end

	assign new_conv = tgl_s2_q ^ tgl_s3_q;

	// Resolution and formatting of the arriving reading
	always_comb begin
		fine = 1'b0;
		if (hold_chan_q == temp_alarm_pkg::CH_REM1) begin
			fine = filter_enable[0];
		end else if (hold_chan_q == temp_alarm_pkg::CH_REM2) begin
			fine = filter_enable[1];
		end
		fmt_s = fmt_signed(hold_raw_q, fine);
		fmt_u = fmt_unsigned(hold_raw_q, fine);
		if (hold_fault_q && hold_chan_q != temp_alarm_pkg::CH_LOCAL) begin
			fmt_s = temp_alarm_pkg::FAULT_S;
			fmt_u = temp_alarm_pkg::FAULT_U;
		end
	end

	// Store readings; zero until the first conversion lands
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < temp_alarm_pkg::NUM_WORDS; i++) begin
				word_q[i] <= temp_alarm_pkg::WORD_ZERO;
			end
		end else if (new_conv) begin
			case (hold_chan_q)
				temp_alarm_pkg::CH_LOCAL: begin
					word_q[temp_alarm_pkg::W_LOC_S] <= fmt_s;
				end
				temp_alarm_pkg::CH_REM1: begin
					word_q[temp_alarm_pkg::W_REM1_S] <= fmt_s;
					word_q[temp_alarm_pkg::W_REM1_U] <= fmt_u;
				end
				temp_alarm_pkg::CH_REM2: begin
					word_q[temp_alarm_pkg::W_REM2_S] <= fmt_s;
					word_q[temp_alarm_pkg::W_REM2_U] <= fmt_u;
				end
				default: begin
				end
			endcase
		end
	end

	// Limit, hysteresis and mask registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			loc_lim_q   <= temp_alarm_pkg::LIM_85_DEF;
			rem1_lim1_q <= temp_alarm_pkg::LIM_110_DEF;
			rem1_lim2_q <= temp_alarm_pkg::LIM_85_DEF;
			rem2_lim1_q <= temp_alarm_pkg::LIM_110_DEF;
			rem2_lim2_q <= temp_alarm_pkg::LIM_85_DEF;
			hyst_q      <= temp_alarm_pkg::HYST_DEF;
			mask1_q     <= temp_alarm_pkg::MASK1_DEF;
			mask2_q     <= temp_alarm_pkg::MASK2_DEF;
			mask3_q     <= temp_alarm_pkg::MASK3_DEF;
		end else if (cfg_we) begin
			case (cfg_sel)
				temp_alarm_pkg::CFG_LOC_LIM:   loc_lim_q   <= cfg_wdata;
				temp_alarm_pkg::CFG_REM1_LIM1: rem1_lim1_q <= cfg_wdata;
				temp_alarm_pkg::CFG_REM2_LIM1: rem2_lim1_q <= cfg_wdata;
				temp_alarm_pkg::CFG_REM1_LIM2: rem1_lim2_q <= cfg_wdata;
				temp_alarm_pkg::CFG_REM2_LIM2: rem2_lim2_q <= cfg_wdata;
				temp_alarm_pkg::CFG_HYST:      hyst_q      <= cfg_wdata;
				temp_alarm_pkg::CFG_MASK1:     mask1_q     <= cfg_wdata[2:0];
				temp_alarm_pkg::CFG_MASK2:     mask2_q     <= cfg_wdata[2:0];
				temp_alarm_pkg::CFG_MASK3:     mask3_q     <= cfg_wdata[2:0];
				default: begin
				end
			endcase
		end
	end

	// Only an enabled channel's fresh reading may move its flags
	assign upd_loc  = new_conv && hold_chan_q == temp_alarm_pkg::CH_LOCAL
		&& chan_enable[temp_alarm_pkg::BIT_LOC];
	assign upd_rem1 = new_conv && hold_chan_q == temp_alarm_pkg::CH_REM1
		&& chan_enable[temp_alarm_pkg::BIT_REM1];
	assign upd_rem2 = new_conv && hold_chan_q == temp_alarm_pkg::CH_REM2
		&& chan_enable[temp_alarm_pkg::BIT_REM2];

	// One comparator per channel and limit; signed word holds filter result
	limit_hyst_cell u_loc (
		.clk(clk), .nrst(nrst), .update(upd_loc), .temp(fmt_s),
		.limit(loc_lim_q), .hyst(hyst_q), .over_q(loc_over));
	limit_hyst_cell u_rem1_l1 (
		.clk(clk), .nrst(nrst), .update(upd_rem1), .temp(fmt_s),
		.limit(rem1_lim1_q), .hyst(hyst_q), .over_q(rem1_over1));
	limit_hyst_cell u_rem1_l2 (
		.clk(clk), .nrst(nrst), .update(upd_rem1), .temp(fmt_s),
		.limit(rem1_lim2_q), .hyst(hyst_q), .over_q(rem1_over2));
	limit_hyst_cell u_rem2_l1 (
		.clk(clk), .nrst(nrst), .update(upd_rem2), .temp(fmt_s),
		.limit(rem2_lim1_q), .hyst(hyst_q), .over_q(rem2_over1));
	limit_hyst_cell u_rem2_l2 (
		.clk(clk), .nrst(nrst), .update(upd_rem2), .temp(fmt_s),
		.limit(rem2_lim2_q), .hyst(hyst_q), .over_q(rem2_over2));

	// Status words; third alarm shares the second limits
	assign status2 = {rem2_over1, rem1_over1, loc_over};
	assign status3 = {rem2_over2, rem1_over2, loc_over};
	assign status4 = {rem2_over2, rem1_over2, loc_over};

	// Alarms: unmasked, enabled flags pull the pin low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			alarm_out_one_oe   <= 1'b0;
			alarm_out_two_oe   <= 1'b0;
			alarm_out_three_oe <= 1'b0;
		end else begin
			alarm_out_one_oe   <= |(status2 & ~mask1_q & chan_enable);
			alarm_out_two_oe   <= |(status3 & ~mask2_q & chan_enable);
			alarm_out_three_oe <= |(status4 & ~mask3_q & chan_enable);
		end
	end

	// Open-drain data levels are constant low; never driven high
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			alarm_out_one_o   <= 1'b0;
			alarm_out_two_o   <= 1'b0;
			alarm_out_three_o <= 1'b0;
			sda_o             <= 1'b0;
			sda_oe            <= 1'b0;
		end else begin
			alarm_out_one_o   <= 1'b0;
			alarm_out_two_o   <= 1'b0;
			alarm_out_three_o <= 1'b0;
			sda_o             <= 1'b0;
			sda_oe            <= sda_drive_low;
		end
	end

	assign rd_pair = rd_sel[3:1];

	// Low byte freeze: each high read relatches, a low read releases
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lock_q <= '0;
			for (int i = 0; i < temp_alarm_pkg::NUM_WORDS; i++) begin
				lo_hold_q[i] <= 8'h00;
			end
		end else if (rd_en && rd_sel < temp_alarm_pkg::RD_STATUS2) begin
			if (!rd_sel[0]) begin
				lock_q[rd_pair]    <= 1'b1;
				lo_hold_q[rd_pair] <= word_q[rd_pair][7:0];
			end else begin
				lock_q[rd_pair] <= 1'b0;
			end
		end
	end

	// Byte readback, registered one cycle after the request
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_data_q <= 8'h00;
		end else if (rd_en) begin
			case (rd_sel)
				temp_alarm_pkg::RD_STATUS2: rd_data_q <= {5'h00, status2};
				temp_alarm_pkg::RD_STATUS3: rd_data_q <= {5'h00, status3};
				temp_alarm_pkg::RD_STATUS4: rd_data_q <= {5'h00, status4};
				default: begin
					if (rd_sel > temp_alarm_pkg::RD_STATUS4) begin
						rd_data_q <= 8'h00;  // Unused selects
					end else if (!rd_sel[0]) begin
						rd_data_q <= word_q[rd_pair][15:8];
					end else if (lock_q[rd_pair]) begin
						rd_data_q <= lo_hold_q[rd_pair];
					end else begin
						rd_data_q <= word_q[rd_pair][7:0];
					end
				end
			endcase
		end
	end
endmodule : temp_alarm_top

`default_nettype wire

// file: conv_model.sv
/*
 * Converter front-end model and pull-ups for the open-drain pins.
 * Assumes the bench calls send only while the link clock stands still.
 */
`default_nettype none

module conv_model (
	// Link to the block
	output var logic        conv_clk,
	output var logic        conv_valid,
	output var logic [1:0]  conv_chan,
	output var logic [15:0] conv_raw,
	output var logic        conv_fault,
	// Open-drain enables in, resolved pin levels out
	input  wire logic [3:0] oe,
	output wire logic [3:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;

	// Pull-ups: a pin is low only while somebody pulls it
	assign pin = ~oe;

	// Link idle, clock parked low
	initial begin
		conv_clk = 1'b0;
		conv_valid = 1'b0;
		conv_chan = 2'h3;
		conv_raw = 16'hA5A5;
		conv_fault = 1'b0;
	end

	// One frame; the link clock runs only inside it
	task automatic send(input logic [1:0] c, input logic [15:0] r,
		input logic f);
		conv_valid = 1'b1;
		conv_chan = c;
		conv_raw = r;
		conv_fault = f;
		#24 conv_clk = 1'b1;
		// Released lines show the inverse so stale data cannot pass
		#1 conv_valid = 1'b0;
		conv_raw = ~r;
		conv_fault = ~f;
		conv_chan = ~c;
		#23 conv_clk = 1'b0;
		#24 conv_clk = 1'b1;
		#24 conv_clk = 1'b0;
	endtask : send
endmodule : conv_model

`default_nettype wire

// file: temp_alarm_monitor.sv
/*
 * Port checker for the temperature alarm block.
 * Assumes it is bound into every instance of temp_alarm_top.
 */
`default_nettype none

module temp_alarm_monitor (
	// Clock and reset
	input wire logic       clk,
	input wire logic       nrst,
	// Controls
	input wire logic [2:0] chan_enable,
	input wire logic       rd_en,
	input wire logic [3:0] rd_sel,
	input wire logic [7:0] rd_data_q,
	input wire logic       sda_drive_low,
	// Pins
	input wire logic       sda_o,
	input wire logic       sda_oe,
	input wire logic       alarm_out_one_o,
	input wire logic       alarm_out_one_oe,
	input wire logic       alarm_out_two_o,
	input wire logic       alarm_out_two_oe,
	input wire logic       alarm_out_three_o,
	input wire logic       alarm_out_three_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// Pins are only ever pulled low or released
	a_sda_low_only: assert property (sda_o == 1'b0)
		else $error("data line driven high");
	a_sda_follows: assert property ($past(nrst) |->
		sda_oe == $past(sda_drive_low)) else $error("data enable lags");
	a_alarm_never_high: assert property (!alarm_out_one_o &&
		!alarm_out_two_o && !alarm_out_three_o)
		else $error("alarm pin driven high");
	// Unused low bits of the words
	a_local_lo_coarse: assert property (rd_en && rd_sel == 4'h1
		|=> rd_data_q[4:0] == 5'h00) else $error("local low bits set");
	a_fine_lo_zero: assert property (rd_en && rd_sel <= 4'h9 &&
		rd_sel[0] |=> rd_data_q[2:0] == 3'h0)
		else $error("bits below fine step set");
	// Read data holds between strobes
	a_rd_hold: assert property (!rd_en |=> $stable(rd_data_q))
		else $error("read data moved");
	a_status_width: assert property (rd_en &&
		rd_sel inside {4'hA, 4'hB, 4'hC} |=> rd_data_q[7:3] == 5'h00)
		else $error("status spare bits set");
	// Disabled channels cannot hold an alarm
	a_disabled_quiet: assert property ((chan_enable == 3'h0)[*2]
		|-> !alarm_out_one_oe && !alarm_out_two_oe && !alarm_out_three_oe)
		else $error("alarm with all channels off");

	c_status_read: cover property (rd_en && rd_sel == 4'hA);
	c_alarm_two: cover property ($rose(alarm_out_two_oe));
	c_all_off: cover property (chan_enable == 3'h0);
endmodule : temp_alarm_monitor

bind temp_alarm_top temp_alarm_monitor temp_alarm_monitor_i (.clk, .nrst,
	.chan_enable, .rd_en, .rd_sel, .rd_data_q, .sda_drive_low, .sda_o,
	.sda_oe, .alarm_out_one_o, .alarm_out_one_oe, .alarm_out_two_o,
	.alarm_out_two_oe, .alarm_out_three_o, .alarm_out_three_oe);

`default_nettype wire

// file: temp_alarm_top_bench.sv
/*
 * Self-checking bench: formatting, limits, masks, coherent reads.
 * Assumes conv_model on the link and the bound port checker.
 */
`default_nettype none

module temp_alarm_top_bench;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk, nrst, conv_clk, conv_valid, conv_fault;
	logic        cfg_we, rd_en, rd_pend, sda_drive_low, sda_o, sda_oe;
	logic        alarm_out_one_o, alarm_out_two_o, alarm_out_three_o;
	logic        alarm_out_one_oe, alarm_out_two_oe, alarm_out_three_oe;
	logic [1:0]  conv_chan, filter_enable;
	logic [2:0]  chan_enable;
	logic [3:0]  cfg_sel, rd_sel, pin;
	logic [7:0]  cfg_wdata, rd_data_q;
	logic [15:0] conv_raw;
	logic [15:0] seed_q = 16'h004E;  // Xorshift seed, 78
	logic [7:0]  rq[$];
	int          err_count, comparisons, cycles;
	int          tbl[9] = '{4000, 4, -4, -1, 6432, 9000, -5000, 1, -1760};
	int          ht[5] = '{2720, 2724, 2592, 2560, 2556};

	temp_alarm_top temp_alarm_top_i (.clk, .nrst, .conv_clk, .conv_valid,
		.conv_chan, .conv_raw, .conv_fault, .chan_enable, .filter_enable,
		.cfg_we, .cfg_sel, .cfg_wdata, .rd_en, .rd_sel, .rd_data_q,
		.sda_drive_low, .sda_o, .sda_oe, .alarm_out_one_o, .alarm_out_one_oe,
		.alarm_out_two_o, .alarm_out_two_oe, .alarm_out_three_o,
		.alarm_out_three_oe);
	conv_model conv_model_i (.conv_clk, .conv_valid, .conv_chan, .conv_raw,
		.conv_fault, .oe({sda_oe, alarm_out_three_oe, alarm_out_two_oe,
		alarm_out_one_oe}), .pin(pin));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [15:0] nxt(input logic [15:0] x);
		x = x ^ (x << 7);
		x = x ^ (x >> 9);
		return x ^ (x << 8);
	endfunction : nxt

	// Expected words: clamp, left-justify, drop unused bits
	function automatic logic [15:0] fs(input int r, input logic fine);
		int c;
		c = r > 4095 ? 4095 : (r < -4096 ? -4096 : r);
		return (16'(c) << 3) & (fine ? 16'hFFF8 : 16'hFFE0);
	endfunction : fs
	function automatic logic [15:0] fu(input int r, input logic fine);
		int c;
		c = r > 8191 ? 8191 : (r < 0 ? 0 : r);
		return (16'(c) << 3) & (fine ? 16'hFFF8 : 16'hFFE0);
	endfunction : fu

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	// Random line drive keeps the data pin logic busy
	always @(posedge clk) begin
		seed_q <= nxt(seed_q);
		sda_drive_low <= seed_q[0];
	end

	// Watcher: read data lands one edge after the strobe
	always @(posedge clk) begin
		if (rd_pend === 1'b1)
			chk(16'(rd_data_q), 16'(rq.pop_front()));
		rd_pend <= rd_en;
	end

	// Hang guard, far above the roughly 1300 cycles needed
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			finish_test();
		end
	end

	task automatic idle;
		@(posedge clk);
		rd_en <= 1'b0;
		cfg_we <= 1'b0;
	endtask : idle
	task automatic rd(input logic [3:0] s, input logic [7:0] e);
		@(posedge clk);
		rd_en <= 1'b1;
		rd_sel <= s;
		rq.push_back(e);
	endtask : rd
	// High byte first, so the pair is coherent
	task automatic rdw(input logic [2:0] p, input logic [15:0] w);
		rd({p, 1'b0}, w[15:8]);
		rd({p, 1'b1}, w[7:0]);
		idle();
	endtask : rdw
	task automatic stat(input logic [2:0] a, input logic [2:0] b);
		rd(4'hA, {5'h00, a});
		rd(4'hB, {5'h00, b});
		rd(4'hC, {5'h00, b});
		idle();
	endtask : stat
	task automatic cfg(input logic [3:0] s, input logic [7:0] d);
		@(posedge clk);
		cfg_we <= 1'b1;
		cfg_sel <= s;
		cfg_wdata <= d;
		idle();
	endtask : cfg
	// Conversion then a wait past the sync and alarm stages
	task automatic conv(input logic [1:0] c, input int r, input logic f);
		conv_model_i.send(c, 16'(r), f);
		repeat (8) @(posedge clk);
	endtask : conv

	initial begin
		int   r;
		logic e;
		nrst = 1'b0;
		{rd_en, cfg_we} = 2'h0;
		{rd_sel, cfg_sel, cfg_wdata} = 16'h0000;
		chan_enable = 3'h7;
		filter_enable = 2'h0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		for (int s = 0; s < 16; s++)
			rd(4'(s), 8'h00);
		idle();
		$display("reset test done");
		for (int i = 0; i < 14; i++) begin
			r = i < 9 ? tbl[i] : int'($signed(seed_q));
			filter_enable <= 2'(i);
			for (int c = 0; c < 3; c++)
				conv(2'(c), r, 1'b0);
			rdw(3'h0, fs(r, 1'b0));
			rdw(3'h1, fs(r, i[0]));
			rdw(3'h2, fs(r, i[1]));
			rdw(3'h3, fu(r, i[0]));
			rdw(3'h4, fu(r, i[1]));
		end
		conv(2'h1, 4000, 1'b1);
		rdw(3'h1, temp_alarm_pkg::FAULT_S);
		rdw(3'h3, temp_alarm_pkg::FAULT_U);
		$display("format test done");
		filter_enable <= 2'h0;
		for (int c = 0; c < 3; c++)
			conv(2'(c), 0, 1'b0);
		for (int i = 0; i < 5; i++) begin
			conv(2'h0, ht[i], 1'b0);
			e = i > 0 && i < 4;
			stat({2'h0, e}, {2'h0, e});
			chk(16'(pin[2:0]), {13'h0, 1'b1, !e, 1'b1});
		end
		conv(2'h1, 3200, 1'b0);
		stat(3'h0, 3'h2);
		chk(16'(pin[2:0]), 16'h0005);
		conv(2'h2, 2721, 1'b0);
		stat(3'h0, 3'h2);
		filter_enable <= 2'h2;
		conv(2'h2, 2721, 1'b0);
		stat(3'h0, 3'h6);
		conv(2'h2, 3552, 1'b0);
		stat(3'h4, 3'h6);
		chk(16'(pin[2:0]), 16'h0004);
		cfg(temp_alarm_pkg::CFG_MASK2, 8'h07);
		cfg(temp_alarm_pkg::CFG_MASK3, 8'h00);
		cfg(4'hF, 8'hFF);
		repeat (2) @(posedge clk);
		chk(16'(pin[2:0]), 16'h0002);
		$display("limit test done");
		chan_enable <= 3'h0;
		repeat (3) @(posedge clk);
		chk(16'(pin[2:0]), 16'h0007);
		conv(2'h2, 0, 1'b0);
		chan_enable <= 3'h7;
		stat(3'h4, 3'h6);
		chk(16'(pin[2:0]), 16'h0002);
		cfg(temp_alarm_pkg::CFG_REM2_LIM1, 8'h7F);
		conv(2'h2, 3552, 1'b0);
		stat(3'h0, 3'h6);
		chk(16'(pin[2:0]), 16'h0003);
		$display("enable test done");
		conv(2'h0, 100, 1'b0);
		rd(4'h0, 8'h03);
		idle();
		conv(2'h0, 108, 1'b0);
		rd(4'h1, 8'h20);
		rd(4'h1, 8'h60);
		idle();
		$display("coherence test done");
		finish_test();
	end
endmodule : temp_alarm_top_bench

`default_nettype wire
